// ### src/adcb_pkg.sv
// converter back end: shared constants, types, rule summary
// assumes one sample clock domain and an internal register port
// ----------------------------------------
// Operation
// RULE1: strap pin picks offset binary or twos complement
// RULE2: register path offers offset, twos, gray
// RULE3: output disable pin high three-states all outputs
// RULE4: per-channel disable bit three-states that channel
// RULE5: fixed nine-cycle pipeline latency
// RULE6: new data after every sample clock edge
// RULE7: two data clocks, polarity selectable
// RULE8: overrange saturates code, raises range flag
// RULE9: both channels muxable onto one bus
// RULE10: self-test injects pseudorandom data, accumulates signature
// RULE11: self-test runs fixed cycles then stops
// RULE12: signature compare sets or clears pass bit
// RULE13: outputs stay connected during self-test
// RULE14: enable plus init bit starts, resets generator
// RULE15: init zero continues generator from last value
// RULE16: software resets device before self-test
// RULE17: test mode replaces core data, formatted
// RULE18: two reset bits reset pattern generators
// RULE19: test modes ignore input, need clock
// RULE20: power-down three-states all outputs
// RULE21: channel off if pin or bit set
// RULE22: gray is xor of adjacent binary bits
// ----------------------------------------
package adcb_pkg;
    localparam int DW = 10;
    localparam int LAT = 9;
    localparam int FIFO_DEPTH = 32;
    localparam int ST_LEN = 512;
    localparam logic [7:0] A_CHAN_SEL = 8'h05;
    localparam logic [7:0] A_PDN = 8'h08;
    localparam logic [7:0] A_TMODE = 8'h0D;
    localparam logic [7:0] A_SELFTEST = 8'h0E;
    localparam logic [7:0] A_OMODE = 8'h14;
    localparam logic [7:0] A_OCTL = 8'h16;
    localparam logic [7:0] A_RESULT = 8'h24;
    localparam int B_ST_EN = 0;
    localparam int B_ST_INIT = 2;
    localparam int B_OFF = 4;
    localparam int B_PNL_RST = 4;
    localparam int B_PNS_RST = 5;
    localparam int B_MUX = 0;
    localparam int B_DCLK_INV = 7;
    localparam int B_BUSY = 7;
    localparam logic [1:0] CHAN_SEL_RST = 2'h3;
    localparam logic [15:0] CRC_SEED = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [DW-1:0] ST_SEED = 10'h3FF;
    localparam logic [22:0] PNL_SEED = 23'h7FFFFF;
    localparam logic [8:0] PNS_SEED = 9'h1FF;
    localparam logic [DW-1:0] CODE_MAX = 10'h3FF;
    localparam logic [DW-1:0] CODE_MID = 10'h200;
    localparam logic [DW-1:0] CODE_MIN = 10'h000;
    localparam logic [DW-1:0] CHK_A = 10'h155;
    localparam logic [DW-1:0] CHK_B = 10'h2AA;
    typedef enum logic [1:0] {
        FMT_OFFSET = 2'b00,
        FMT_TWOS = 2'b01,
        FMT_GRAY = 2'b10
    } adcb_fmt_t;
    typedef struct packed {
        logic ovr;
        logic unr;
        logic [DW-1:0] code;
    } adcb_samp_t;
    typedef struct packed {
        adcb_samp_t a;
        adcb_samp_t b;
    } adcb_pair_t;
endpackage

// ### src/adcb_top.sv
// converter back end: input fifo, pipeline, formatter, self-test, pins
// assumes the core delivers samples on clk_sys; pins are asynchronous
`timescale 1ns/1ps

// ----------------------------------------
// sample fifo
// ----------------------------------------
module adcb_fifo #(
    parameter int W = 24,
    parameter int D = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = cnt_r != (AW+1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rd_ptr_r];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------
// back end top
// ----------------------------------------
module adcb_top #(
    parameter int LAT = adcb_pkg::LAT,
    parameter int DEPTH = adcb_pkg::FIFO_DEPTH,
    parameter int ST_LEN = adcb_pkg::ST_LEN,
    parameter logic [15:0] ST_SIG = 16'h5A5A
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic core_valid,
    output logic core_ready,
    input wire adcb_pkg::adcb_pair_t core_data,
    input wire logic output_disable,
    input wire logic power_down_pin,
    input wire logic format_strap_pin,
    output logic [adcb_pkg::DW-1:0] dout_a,
    output logic [adcb_pkg::DW-1:0] dout_b,
    output logic or_a,
    output logic or_b,
    output logic data_clock_out_a,
    output logic data_clock_out_b,
    output logic out_en_n_a,
    output logic out_en_n_b
);
    localparam int DW = adcb_pkg::DW;
    localparam int CW = $clog2(ST_LEN);

    function automatic logic [DW-1:0] fmt_code(input logic [DW-1:0] c,
                                               input logic [1:0] f);
        unique case (f)
            adcb_pkg::FMT_TWOS: fmt_code = {~c[DW-1], c[DW-2:0]};
            adcb_pkg::FMT_GRAY: fmt_code = c ^ (c >> 1); // RULE22
            default: fmt_code = c;
        endcase
    endfunction

    function automatic adcb_pkg::adcb_samp_t sat(input adcb_pkg::adcb_samp_t s);
        sat = s;
        if (s.ovr) begin
            sat.code = adcb_pkg::CODE_MAX; // RULE8
        end else if (s.unr) begin
            sat.code = adcb_pkg::CODE_MIN;
        end
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [DW-1:0] d);
        crc_step = c;
        for (int i = DW - 1; i >= 0; i--) begin
            crc_step = {crc_step[14:0], 1'b0}
                ^ ((crc_step[15] ^ d[i]) ? adcb_pkg::CRC_POLY : 16'h0000);
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic odis_s;
    logic pdn_s;
    logic strap_s;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else if (ce) begin
            pin_s1_r <= {format_strap_pin, power_down_pin, output_disable};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign odis_s = pin_s2_r[0];
    assign pdn_s = pin_s2_r[1];
    assign strap_s = pin_s2_r[2];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [1:0] chan_sel_r;
    logic [1:0] pdn_r;
    logic [7:0] tmode_r;
    logic [7:0] st_ctl_r;
    logic [7:0] omode_a_r;
    logic [7:0] omode_b_r;
    logic [7:0] octl_r;
    logic fmt_soft_r;
    logic pass_r;
    logic busy_r;
    logic wr;
    logic pdn;

    assign wr = ce && reg_wr;
    assign pdn = pdn_s || (pdn_r != '0);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chan_sel_r <= adcb_pkg::CHAN_SEL_RST;
            pdn_r <= '0;
            tmode_r <= '0;
            st_ctl_r <= '0;
            octl_r <= '0;
        end else if (wr) begin
            unique case (reg_addr)
                adcb_pkg::A_CHAN_SEL: chan_sel_r <= reg_wdata[1:0];
                adcb_pkg::A_PDN: pdn_r <= reg_wdata[1:0];
                adcb_pkg::A_TMODE: tmode_r <= reg_wdata;
                adcb_pkg::A_SELFTEST: st_ctl_r <= reg_wdata;
                adcb_pkg::A_OCTL: octl_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // per-channel mode, applied to the channels picked by chan_sel_r
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            omode_a_r <= '0;
            omode_b_r <= '0;
            fmt_soft_r <= 1'b0;
        end else if (wr && reg_addr == adcb_pkg::A_OMODE) begin
            fmt_soft_r <= 1'b1; // RULE2
            if (chan_sel_r[0]) begin
                omode_a_r <= reg_wdata; // RULE4
            end
            if (chan_sel_r[1]) begin
                omode_b_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            unique case (reg_addr)
                adcb_pkg::A_CHAN_SEL: reg_rdata <= {6'h00, chan_sel_r};
                adcb_pkg::A_PDN: reg_rdata <= {6'h00, pdn_r};
                adcb_pkg::A_TMODE: reg_rdata <= tmode_r;
                adcb_pkg::A_SELFTEST: reg_rdata <= st_ctl_r;
                adcb_pkg::A_OMODE: reg_rdata <= chan_sel_r[0] ? omode_a_r : omode_b_r;
                adcb_pkg::A_OCTL: reg_rdata <= octl_r;
                adcb_pkg::A_RESULT: reg_rdata <= {busy_r, 6'h00, pass_r};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // self-test
    // ----------------------------------------
    logic [DW-1:0] bpn_r;
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;
    logic [CW-1:0] bcnt_r;
    logic start;
    logic st_end;

    assign start = wr && reg_addr == adcb_pkg::A_SELFTEST && reg_wdata[adcb_pkg::B_ST_EN];
    assign crc_nxt = crc_step(crc_r, bpn_r); // RULE10
    assign st_end = busy_r && bcnt_r == CW'(ST_LEN - 1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            bcnt_r <= '0;
            crc_r <= adcb_pkg::CRC_SEED;
            pass_r <= 1'b0;
        end else if (start) begin
            busy_r <= 1'b1;
            bcnt_r <= '0;
            crc_r <= adcb_pkg::CRC_SEED;
            pass_r <= 1'b0;
        end else if (ce && busy_r) begin
            crc_r <= crc_nxt;
            bcnt_r <= bcnt_r + 1'b1;
            if (st_end) begin
                busy_r <= 1'b0; // RULE11
                pass_r <= crc_nxt == ST_SIG; // RULE12
            end
        end
    end

    // init reseeds; without it the generator resumes, so the sum differs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bpn_r <= adcb_pkg::ST_SEED;
        end else if (start && reg_wdata[adcb_pkg::B_ST_INIT]) begin
            bpn_r <= adcb_pkg::ST_SEED; // RULE14
        end else if (ce && busy_r) begin
            bpn_r <= {bpn_r[DW-2:0], bpn_r[9] ^ bpn_r[6]}; // RULE15
        end
    end

    // ----------------------------------------
    // output test pattern generators
    // ----------------------------------------
    logic [22:0] pnl_r;
    logic [8:0] pns_r;
    logic tog_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pnl_r <= adcb_pkg::PNL_SEED;
            pns_r <= adcb_pkg::PNS_SEED;
            tog_r <= 1'b0;
        end else if (ce) begin
            tog_r <= ~tog_r;
            if (tmode_r[adcb_pkg::B_PNL_RST]) begin
                pnl_r <= adcb_pkg::PNL_SEED; // RULE18
            end else begin
                pnl_r <= {pnl_r[21:0], pnl_r[22] ^ pnl_r[17]};
            end
            if (tmode_r[adcb_pkg::B_PNS_RST]) begin
                pns_r <= adcb_pkg::PNS_SEED; // RULE18
            end else begin
                pns_r <= {pns_r[7:0], pns_r[8] ^ pns_r[4]};
            end
        end
    end

    // ----------------------------------------
    // source select and pipeline
    // ----------------------------------------
    adcb_pkg::adcb_pair_t fifo_data;
    adcb_pkg::adcb_pair_t raw_w;
    adcb_pkg::adcb_pair_t hold_r;
    adcb_pkg::adcb_pair_t pipe_r [LAT-1];
    adcb_pkg::adcb_samp_t pat;
    logic fifo_valid;
    logic drain;

    // power-down stalls the drain, so the fifo fills and back-pressures the core
    assign drain = !pdn;

    adcb_fifo #(
        .W($bits(adcb_pkg::adcb_pair_t)),
        .D(DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .in_valid(core_valid),
        .in_ready(core_ready),
        .in_data(core_data),
        .out_valid(fifo_valid),
        .out_ready(drain),
        .out_data(fifo_data)
    );

    always_comb begin
        pat = '0;
        unique case (tmode_r[3:0])
            4'h1: pat.code = adcb_pkg::CODE_MID;
            4'h2: pat.code = adcb_pkg::CODE_MAX;
            4'h3: pat.code = adcb_pkg::CODE_MIN;
            4'h4: pat.code = tog_r ? adcb_pkg::CHK_B : adcb_pkg::CHK_A;
            4'h5: pat.code = pnl_r[DW-1:0];
            4'h6: pat.code = {pns_r, pns_r[8]};
            default: pat.code = tog_r ? adcb_pkg::CODE_MAX : adcb_pkg::CODE_MIN;
        endcase
    end

    always_comb begin
        if (busy_r) begin
            raw_w.a = '{ovr: 1'b0, unr: 1'b0, code: bpn_r}; // RULE10
            raw_w.b = '{ovr: 1'b0, unr: 1'b0, code: bpn_r};
        end else if (tmode_r[3:0] != 4'h0) begin
            raw_w.a = pat; // RULE17 RULE19
            raw_w.b = pat;
        end else if (fifo_valid && drain) begin
            raw_w.a = sat(fifo_data.a);
            raw_w.b = sat(fifo_data.b);
        end else begin
            raw_w = hold_r;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_r <= '0;
            for (int i = 0; i < LAT - 1; i++) begin
                pipe_r[i] <= '0;
            end
        end else if (ce) begin
            hold_r <= raw_w;
            pipe_r[0] <= raw_w; // RULE5
            for (int i = 1; i < LAT - 1; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    // ----------------------------------------
    // formatter and output drivers
    // ----------------------------------------
    adcb_pkg::adcb_samp_t tail_a;
    adcb_pkg::adcb_samp_t tail_b;
    logic [1:0] fmt_a;
    logic [1:0] fmt_b;
    logic mux_ph_r;
    logic dclk_r;
    logic mux_en;

    assign tail_a = pipe_r[LAT-2].a;
    assign tail_b = pipe_r[LAT-2].b;
    assign mux_en = octl_r[adcb_pkg::B_MUX];
    assign fmt_a = fmt_soft_r ? omode_a_r[1:0] : {1'b0, strap_s}; // RULE1
    assign fmt_b = fmt_soft_r ? omode_b_r[1:0] : {1'b0, strap_s};

    // self-test does not touch the enables, so its data stays visible
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_en_n_a <= 1'b1;
            out_en_n_b <= 1'b1;
        end else if (ce) begin
            out_en_n_a <= odis_s || pdn || omode_a_r[adcb_pkg::B_OFF]; // RULE3 RULE21 RULE13
            out_en_n_b <= odis_s || pdn || omode_b_r[adcb_pkg::B_OFF] || mux_en; // RULE20
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dout_a <= '0;
            dout_b <= '0;
            or_a <= 1'b0;
            or_b <= 1'b0;
            mux_ph_r <= 1'b0;
            dclk_r <= 1'b0;
        end else if (ce) begin
            dclk_r <= ~dclk_r; // RULE6
            mux_ph_r <= mux_en ? ~mux_ph_r : 1'b0;
            if (mux_en && mux_ph_r) begin
                dout_a <= fmt_code(tail_b.code, fmt_b); // RULE9
                or_a <= tail_b.ovr || tail_b.unr;
            end else begin
                dout_a <= fmt_code(tail_a.code, fmt_a);
                or_a <= tail_a.ovr || tail_a.unr; // RULE8
            end
            dout_b <= fmt_code(tail_b.code, fmt_b);
            or_b <= tail_b.ovr || tail_b.unr;
        end
    end

    assign data_clock_out_a = dclk_r ^ octl_r[adcb_pkg::B_DCLK_INV]; // RULE7
    assign data_clock_out_b = dclk_r ^ octl_r[adcb_pkg::B_DCLK_INV];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_pin_off;
        ce && odis_s |=> out_en_n_a && out_en_n_b;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin disable ignored"); // RULE3

    property p_chan_off;
        ce && !odis_s && !pdn && !omode_a_r[adcb_pkg::B_OFF] ##1 ce && omode_a_r[adcb_pkg::B_OFF]
            |=> out_en_n_a;
    endproperty
    a_chan_off: assert property (p_chan_off) else $error("channel disable ignored"); // RULE4

    property p_pdn_off;
        ce && pdn |=> out_en_n_a && out_en_n_b;
    endproperty
    a_pdn_off: assert property (p_pdn_off) else $error("outputs driven in power-down"); // RULE20

    property p_st_stop;
        start ##1 (ce && busy_r && !start)[*8] |=> bcnt_r == CW'(8);
    endproperty
    a_st_stop: assert property (p_st_stop) else $error("self-test count wrong"); // RULE11

    property p_st_end;
        ce && st_end && !start |=> !busy_r && pass_r == ($past(crc_nxt) == ST_SIG);
    endproperty
    a_st_end: assert property (p_st_end) else $error("self-test result wrong"); // RULE12

    property p_init;
        start && reg_wdata[adcb_pkg::B_ST_INIT] |=> busy_r && bpn_r == adcb_pkg::ST_SEED;
    endproperty
    a_init: assert property (p_init) else $error("generator not reseeded"); // RULE14

    property p_pat_rst;
        ce && tmode_r[adcb_pkg::B_PNL_RST] |=> pnl_r == adcb_pkg::PNL_SEED;
    endproperty
    a_pat_rst: assert property (p_pat_rst) else $error("pattern reset ignored"); // RULE18

    property p_sat;
        ce && !mux_en && tail_a.ovr && fmt_a == adcb_pkg::FMT_OFFSET
            |=> or_a && dout_a == adcb_pkg::CODE_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("overrange not saturated"); // RULE8
endmodule

// ### testbench/adcb_capture.sv
// external capture register: samples one channel on its data clock
// assumes dout and the data clock leave the same flop stage together
`timescale 1ns/1ps

// ----------------------------------------
// capture model
// ----------------------------------------
module adcb_capture (
    input wire logic dclk,
    input wire logic inv,
    input wire logic en_n,
    input wire logic [adcb_pkg::DW-1:0] dout,
    output logic [adcb_pkg::DW-1:0] cap,
    output int caps
);
    int caps_r = 0;

    assign caps = caps_r;
    // a three-stated bus carries nothing valid, so it is not captured
    // sampling waits past the launch step, else data and clock would race
    always @(posedge dclk or negedge dclk) begin
        #1;
        if ((dclk ^ inv) && !en_n) begin
            cap <= dout;
            caps_r <= caps_r + 1;
        end
    end
endmodule

// ### testbench/tb.sv
// self-checking bench for the converter back end
// assumes the bench stands in for the core and the register port master
`timescale 1ns/1ps

// ----------------------------------------
// bench top
// ----------------------------------------
module tb;
    localparam int BL = 16;
    localparam int L = adcb_pkg::LAT;
    localparam logic [15:0] SIG = sig_ref(BL);
    logic clk_sys, rst, ce, reg_wr, core_valid, core_ready, inv;
    logic output_disable, power_down_pin, format_strap_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    adcb_pkg::adcb_pair_t core_data;
    logic [9:0] dout_a, dout_b, cap, v0;
    logic [7:0] tm [5] = '{8'h04, 8'h26, 8'h06, 8'h15, 8'h07};
    logic or_a, or_b, data_clock_out_a, data_clock_out_b, out_en_n_a, out_en_n_b;
    int num_errors = 0, checks = 0, cyc = 0, caps, t0, n;
    adcb_top #(.ST_LEN(BL), .ST_SIG(SIG)) DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .core_valid(core_valid), .core_ready(core_ready), .core_data(core_data),
        .output_disable(output_disable), .power_down_pin(power_down_pin),
        .format_strap_pin(format_strap_pin), .dout_a(dout_a), .dout_b(dout_b), .or_a(or_a),
        .or_b(or_b), .data_clock_out_a(data_clock_out_a), .data_clock_out_b(data_clock_out_b),
        .out_en_n_a(out_en_n_a), .out_en_n_b(out_en_n_b));
    adcb_capture cap_a (.dclk(data_clock_out_a), .inv(inv), .en_n(out_en_n_a), .dout(dout_a),
        .cap(cap), .caps(caps));
    // reference signature: crc over the lfsr words, msb first
    function automatic logic [15:0] sig_ref(input int k);
        logic [9:0] pn;
        logic [15:0] c;
        pn = adcb_pkg::ST_SEED;
        c = adcb_pkg::CRC_SEED;
        for (int i = 0; i < k; i++) begin
            for (int b = 9; b >= 0; b--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ pn[b]) ? adcb_pkg::CRC_POLY : 16'h0000);
            end
            pn = {pn[8:0], pn[9] ^ pn[6]};
        end
        return c;
    endfunction
    function automatic adcb_pkg::adcb_pair_t mk(input logic [11:0] a, input logic [11:0] b);
        return {a, b};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        v = reg_rdata;
    endtask
    // holds valid until a ready edge takes the sample
    task automatic send(input adcb_pkg::adcb_pair_t p);
        core_data <= p;
        core_valid <= 1'b1;
        do @(posedge clk_sys); while (core_ready !== 1'b1);
    endtask
    task automatic look(input adcb_pkg::adcb_pair_t p);
        @(posedge clk_sys);
        send(p);
        core_valid <= 1'b0;
        repeat (L + 4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic settle();
        repeat (L + 4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic run_st(input logic [7:0] v);
        wr(adcb_pkg::A_SELFTEST, v);
        t0 = cyc;
        n = 0;
        do begin
            rd(adcb_pkg::A_RESULT, d);
            n++;
        end while (d[7] !== 1'b0 && n < 50);
    endtask
    task automatic end_of_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        {rst, ce, reg_wr, core_valid, inv, output_disable, power_down_pin} = 7'b1100000;
        {reg_addr, reg_wdata} = 16'h0000;
        core_data = '0;
        format_strap_pin = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        look(mk(12'h0C5, 12'h0C5));
        check(dout_a, 16'h02C5);
        format_strap_pin <= 1'b0;
        settle();
        check(dout_a, 16'h00C5);
        $display("strap format done");
        @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            send(mk(12'h120 + 12'(i), 12'h000));
            if (i == 0) t0 = cyc;
        end
        core_valid <= 1'b0;
        n = 0;
        // the count includes the edge that took the first sample
        while (dout_a !== 10'h120 && n < 30) begin
            @(negedge clk_sys);
            n++;
        end
        check(16'(cyc - t0), 16'(L + 1));
        for (int i = 1; i < 4; i++) begin
            @(negedge clk_sys);
            check(dout_a, 16'h0120 + 16'(i));
        end
        $display("latency done");
        for (int f = 0; f < 4; f++) begin
            wr(adcb_pkg::A_OMODE, 8'(f));
            settle();
            v0 = (f == 1) ? 10'h323 : (f == 2) ? 10'h123 ^ 10'h091 : 10'h123;
            check(dout_a, v0);
        end
        wr(adcb_pkg::A_OMODE, 8'h00);
        look(mk(12'h955, 12'h555));
        check({or_a, dout_a, or_b, dout_b}, {1'b1, 10'h3FF, 1'b1, 10'h000});
        look(mk(12'h0AA, 12'h0AA));
        check({or_a, or_b}, 2'b00);
        $display("format and range done");
        output_disable <= 1'b1;
        settle();
        check({out_en_n_a, out_en_n_b}, 2'b11);
        output_disable <= 1'b0;
        wr(adcb_pkg::A_CHAN_SEL, 8'h01);
        wr(adcb_pkg::A_OMODE, 8'h10);
        settle();
        check({out_en_n_a, out_en_n_b}, 2'b10);
        wr(adcb_pkg::A_OMODE, 8'h00);
        wr(adcb_pkg::A_CHAN_SEL, 8'h03);
        power_down_pin <= 1'b1;
        settle();
        check({out_en_n_a, out_en_n_b}, 2'b11);
        power_down_pin <= 1'b0;
        settle();
        check({out_en_n_a, out_en_n_b}, 2'b00);
        $display("three-state done");
        wr(adcb_pkg::A_OCTL, 8'h01);
        look(mk(12'h111, 12'h222));
        v0 = dout_a;
        @(negedge clk_sys);
        check({v0 ^ dout_a, out_en_n_b}, {10'h333, 1'b1});
        wr(adcb_pkg::A_OCTL, 8'h80);
        inv <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            settle();
            n = caps;
            v0 = {9'h000, data_clock_out_a};
            @(negedge clk_sys);
            check({data_clock_out_a, data_clock_out_b}, {2{~v0[0]}});
            repeat (6) @(negedge clk_sys);
            check({cap == dout_a, caps - n >= 2}, 2'b11);
            wr(adcb_pkg::A_OCTL, 8'h00);
            inv <= 1'b0;
        end
        $display("mux and data clock done");
        wr(adcb_pkg::A_PDN, 8'h01);
        settle();
        n = 0;
        for (int i = 0; i < 40; i++) begin
            core_data <= mk(12'(i), 12'(i));
            core_valid <= 1'b1;
            @(posedge clk_sys);
            if (core_ready === 1'b1) n++;
        end
        core_valid <= 1'b0;
        check(16'(n), 16'(adcb_pkg::FIFO_DEPTH));
        check({out_en_n_a, out_en_n_b}, 2'b11);
        wr(adcb_pkg::A_PDN, 8'h00);
        repeat (40) @(posedge clk_sys);
        check(core_ready, 1'b1);
        $display("buffer done");
        for (int m = 1; m < 4; m++) begin
            wr(adcb_pkg::A_TMODE, 8'(m));
            settle();
            check(dout_a, (m == 1) ? 10'h200 : (m == 2) ? 10'h3FF : 10'h000);
        end
        foreach (v0[i]) v0[i] = 1'b0;
        for (int m = 0; m < 5; m++) begin
            wr(adcb_pkg::A_TMODE, tm[m]);
            settle();
            v0 = dout_a;
            @(negedge clk_sys);
            check(v0 == dout_a, m == 1 || m == 3);
        end
        wr(adcb_pkg::A_TMODE, 8'h00);
        $display("test patterns done");
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        wr(adcb_pkg::A_SELFTEST, 8'h05);
        rd(adcb_pkg::A_RESULT, d);
        check({d[7], d[0], out_en_n_a}, 3'b100);
        repeat (BL) @(posedge clk_sys);
        run_st(8'h05);
        check(d, 8'h01);
        check(16'(cyc - t0) >= BL && 16'(cyc - t0) <= BL + 10, 1'b1);
        run_st(8'h01);
        check(d, 8'h00);
        wr(adcb_pkg::A_RESULT, 8'hFF);
        rd(adcb_pkg::A_RESULT, d);
        check(d, 8'h00);
        rd(8'h30, d);
        check(d, 8'h00);
        $display("self-test done");
        end_of_test();
    end
endmodule
